// ---- rtl/adc_output_port.sv ----
// Operation
// - results leave as 12-bit offset binary, mid-scale is top bit only
// - sustains 40 Msps, one new word per clock
// - sample taken on rising clock edge, one per period
// - enable low drives all twelve data pins with current word
// - enable high releases all data pins to high impedance
// - sleep request high stops conversion, low-power mode
// - sleep request low runs conversions every clock
// - lsb on bit 0, msb on bit 11, same order at capture
`timescale 1ns/10ps
`default_nettype none
module adc_output_port
  import adc_port_pkg::*;
#(
  parameter int unsigned LATENCY = adc_port_pkg::PIPE_LATENCY,
  parameter int unsigned DEPTH   = adc_port_pkg::FIFO_DEPTH
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_n,
  input  wire logic                          i_ce,
  input  wire logic signed [adc_port_pkg::WORD_W-1:0] i_quant,
  input  wire logic                          i_oe_n,
  input  wire logic                          i_sleep_request,
  output logic [adc_port_pkg::WORD_W-1:0]    o_sample_word,
  output logic [adc_port_pkg::WORD_W-1:0]    o_sample_word_oe,
  output logic                               o_awake
);
  import adc_port_pkg::*;

  // refused early: valid shift needs two stages, fill count fits eight bits
  if (LATENCY < 2 || LATENCY > 64) begin : g_bad_latency
    $error("latency must lie in 2..64");
  end
  if (DEPTH < 2) begin : g_bad_depth
    $error("fifo depth must be at least 2");
  end

  // ---------------------------------------------------------------
  // pin synchronisers, three stages, accept when 2nd and 3rd agree
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] oe_sync_q;
  logic [SYNC_STAGES-1:0] slp_sync_q;
  logic                   oe_n_q;
  logic                   sleep_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_sync_q  <= '1;
      slp_sync_q <= '1;
    end else if (i_ce) begin
      oe_sync_q  <= {oe_sync_q[SYNC_STAGES-2:0], i_oe_n};
      slp_sync_q <= {slp_sync_q[SYNC_STAGES-2:0], i_sleep_request};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_n_q  <= 1'b1;
      sleep_q <= 1'b1;
    end else if (i_ce) begin
      if (oe_sync_q[1] == oe_sync_q[2]) begin
        oe_n_q <= oe_sync_q[2];
      end
      if (slp_sync_q[1] == slp_sync_q[2]) begin
        sleep_q <= slp_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // sample and pipeline
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] pipe_q [LATENCY];
  logic [LATENCY-1:0] vld_q;
  logic               run;

  assign run = !sleep_q;

  // two's complement quantiser code to offset binary: flip the msb
  always_ff @(posedge i_mclk) begin
    if (i_ce && run) begin
      pipe_q[0] <= {~i_quant[WORD_W-1], i_quant[WORD_W-2:0]};
    end
  end

  genvar g;
  generate
    for (g = 1; g < LATENCY; g++) begin : g_stage
      always_ff @(posedge i_mclk) begin
        if (i_ce && run) begin
          pipe_q[g] <= pipe_q[g-1];
        end
      end
      a_stage_shift : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_ce && run && vld_q[g-1]) |=> (pipe_q[g] == $past(pipe_q[g-1])))
        else $error("pipeline stage skipped a word");
    end
  endgenerate

  // flush on sleep so no stale word leaks out after wake-up
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vld_q <= '0;
    end else if (i_ce) begin
      if (!run) begin
        vld_q <= '0;
      end else begin
        vld_q <= {vld_q[LATENCY-2:0], 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------
  // run length since the last wake-up
  // ---------------------------------------------------------------
  // saturates so a long run never wraps and looks like a fresh wake-up
  logic [7:0] fill_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_q <= '0;
    end else if (i_ce) begin
      if (!run) begin
        fill_q <= '0;
      end else if (fill_q != 8'hff) begin
        fill_q <= fill_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // output fifo, drained every clock while awake
  // ---------------------------------------------------------------
  word_stream_if #(.W(WORD_W)) fin ();
  word_stream_if #(.W(WORD_W)) fout ();

  assign fin.data  = pipe_q[LATENCY-1];
  assign fin.valid = vld_q[LATENCY-1] && run;
  assign fout.ready = run;

  word_fifo #(
    .W     (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_flush (!run),
    .wr      (fin),
    .rd      (fout)
  );

  // ---------------------------------------------------------------
  // pin drivers, word held between updates
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_word <= WORD_RESET;
    end else if (i_ce && fout.valid && fout.ready) begin
      o_sample_word <= fout.data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample_word_oe <= '0;
    end else if (i_ce) begin
      o_sample_word_oe <= {WORD_W{!oe_n_q}};
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awake <= 1'b0;
    end else if (i_ce) begin
      o_awake <= run;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mid_scale_map : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run && i_quant == '0) |=> (pipe_q[0] == MID_SCALE))
    else $error("zero code not mapped to mid-scale");

  a_latency_fixed : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run && vld_q[LATENCY-2] && !vld_q[LATENCY-1]) |=> vld_q[LATENCY-1] || !run)
    else $error("pipeline valid did not advance");

  a_word_per_clock : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run && fout.valid) |=> (o_sample_word == $past(fout.data)))
    else $error("word not presented on the next clock");

  a_drive_on_en : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !oe_n_q) |=> (o_sample_word_oe == '1))
    else $error("pins not driven while enabled");

  a_release_on_dis : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && oe_n_q) |=> (o_sample_word_oe == '0))
    else $error("pins driven while disabled");

  a_sleep_stops : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && sleep_q) |=> (vld_q == '0 && !o_awake))
    else $error("conversion active in sleep");

  a_awake_runs : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !sleep_q) |=> (vld_q[0] && o_awake))
    else $error("no conversion while awake");

  a_word_hold : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_ce |=> $stable(o_sample_word))
    else $error("word changed with clock enable low");

  a_sample_edge : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run) |=> (pipe_q[0][WORD_W-2:0] == $past(i_quant[WORD_W-2:0])))
    else $error("sample not taken on rising edge");

  // ---------------------------------------------------------------
  // checks: pipeline fill and fifo
  // ---------------------------------------------------------------
  a_msb_flipped : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run) |=> (pipe_q[0][WORD_W-1] != $past(i_quant[WORD_W-1])))
    else $error("sign bit not inverted into offset binary");

  a_no_early_word : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (run && fill_q < 8'(LATENCY)) |-> !fin.valid)
    else $error("word left the pipeline before its latency");

  a_fifo_empty_fill : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (run && fill_q <= 8'(LATENCY)) |-> !fout.valid)
    else $error("fifo offered a word before the pipeline filled");

  a_fill_on_time : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run && fill_q == 8'(LATENCY - 1)) |=> (fin.valid || !run))
    else $error("first word late out of the pipeline");

  a_stream_steady : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (run && fill_q > 8'(LATENCY)) |-> (fin.valid && fout.valid))
    else $error("gap in the word stream while awake");

  a_fifo_drained : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    fin.valid |-> fin.ready)
    else $error("fifo full, a word would be dropped");

  // ---------------------------------------------------------------
  // checks: sleep, clock enable and pin enables
  // ---------------------------------------------------------------
  a_sleep_flushes : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !run) |=> !fout.valid)
    else $error("fifo kept a word across sleep");

  a_sleep_no_word : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !run) |=> $stable(o_sample_word))
    else $error("new word presented while asleep");

  a_sleep_no_output : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && sleep_q) |=> (!fin.valid && !fout.valid))
    else $error("words still moving while asleep");

  a_awake_mirror : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_ce |=> (o_awake == $past(run)))
    else $error("awake flag does not follow the run state");

  a_fill_advances : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run) |=> (fill_q != '0))
    else $error("awake clock not counted as a conversion");

  a_word_only_new : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && !(fout.valid && fout.ready)) |=> $stable(o_sample_word))
    else $error("word changed without a fifo read");

  a_oe_in_sleep : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && sleep_q && !oe_n_q) |=> (o_sample_word_oe == '1))
    else $error("sleep released the enabled pins");

  a_release_while_awake : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && run && oe_n_q) |=> (o_sample_word_oe == '0 && o_awake))
    else $error("release disturbed conversion or left pins driven");

  a_oe_filter : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && oe_sync_q[1] != oe_sync_q[2]) |=> $stable(oe_n_q))
    else $error("enable accepted before two stages agreed");

  a_sleep_filter : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_ce && slp_sync_q[1] != slp_sync_q[2]) |=> $stable(sleep_q))
    else $error("sleep accepted before two stages agreed");

  a_ce_freeze : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_ce |=> ($stable(o_sample_word_oe) && $stable(o_awake) && $stable(vld_q)))
    else $error("state moved with clock enable low");

  // ---------------------------------------------------------------
  // checks: per-bit lanes and enables
  // ---------------------------------------------------------------
  for (g = 0; g < WORD_W; g++) begin : g_bit_check
    a_bit_lane : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && fout.valid && fout.ready) |=> (o_sample_word[g] == $past(fout.data[g])))
      else $error("data bit left its lane");
    a_bit_enable : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_sample_word_oe[g] == o_sample_word_oe[0])
      else $error("pin enables differ between bits");
  end
endmodule
`default_nettype wire

// ---- rtl/adc_port_pkg.sv ----
package adc_port_pkg;
  // ---------------------------------------------------------------
  // data format
  // ---------------------------------------------------------------
  localparam int unsigned          WORD_W       = 12;
  localparam logic [WORD_W-1:0]    MID_SCALE    = 12'h800;
  localparam logic [WORD_W-1:0]    WORD_RESET   = 12'h000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned          MIN_RATE_MSPS = 40;
  localparam int unsigned          PIPE_LATENCY  = 6;
  localparam int unsigned          FIFO_DEPTH    = 4;
  localparam int unsigned          SYNC_STAGES   = 3;
endpackage

// ---- rtl/word_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int unsigned W     = 12,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic      i_mclk,
  input  wire logic      i_rst_n,
  input  wire logic      i_ce,
  input  wire logic      i_flush,
  word_stream_if.dst     wr,
  word_stream_if.src     rd
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two >= 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_q;
  logic [AW:0]   rp_q;
  logic          full;
  logic          empty;

  // ---------------------------------------------------------------
  // pointers, extra bit tells full from empty
  // ---------------------------------------------------------------
  assign empty    = (wp_q == rp_q);
  assign full     = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        wp_q <= '0;
      end else if (wr.valid && !full) begin
        wp_q <= wp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rp_q <= '0;
    end else if (i_ce) begin
      if (i_flush) begin
        rp_q <= '0;
      end else if (rd.ready && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_ce && !i_flush && wr.valid && !full) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  a_fifo_no_overrun : assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    full |-> ##1 (wp_q == $past(wp_q) || $past(i_flush) || !$past(i_ce)))
    else $error("fifo write pointer moved while full");
endmodule
`default_nettype wire

// ---- rtl/word_stream_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface word_stream_if #(parameter int unsigned W = 12);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface
`default_nettype wire

// ---- tb/capture_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module capture_model
  import adc_port_pkg::*;
(
  input  wire logic                            i_mclk,
  input  wire logic [adc_port_pkg::WORD_W-1:0] i_pins,
  input  wire logic [adc_port_pkg::WORD_W-1:0] i_pins_oe,
  output logic      [adc_port_pkg::WORD_W-1:0] o_word
);
  import adc_port_pkg::*;
  // ---------------------------------------------------------------
  // bus capture
  // ---------------------------------------------------------------
  // released bits float: show the inverse of the last value
  initial o_word = '0;
  always @(posedge i_mclk) begin
    for (int b = 0; b < WORD_W; b++) begin
      o_word[b] <= i_pins_oe[b] ? i_pins[b] : ~o_word[b];
    end
  end
endmodule
`default_nettype wire

// ---- tb/pipelined_adc_output_port_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module pipelined_adc_output_port_bench;
  import adc_port_pkg::*;
  localparam int unsigned LAT = 4;
  logic                     mclk  = 0;
  logic                     rst_n = 0;
  logic                     ce    = 1;
  logic                     oe_n  = 0;
  logic                     sleep = 0;
  logic signed [WORD_W-1:0] quant = '0;
  logic        [WORD_W-1:0] word;
  logic        [WORD_W-1:0] word_oe;
  logic        [WORD_W-1:0] cap;
  logic        [WORD_W-1:0] hold;
  logic                     awake;
  logic        [WORD_W-1:0] expq[$];
  int                       err_count = 0;
  int                       checked = 0;
  always #25 mclk = ~mclk;
  adc_output_port #(.LATENCY(LAT), .DEPTH(FIFO_DEPTH)) adc_output_port_i (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_quant(quant), .i_oe_n(oe_n),
    .i_sleep_request(sleep), .o_sample_word(word), .o_sample_word_oe(word_oe),
    .o_awake(awake));
  capture_model capture_model_i (
    .i_mclk(mclk), .i_pins(word), .i_pins_oe(word_oe), .o_word(cap));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [WORD_W-1:0] conv(input logic signed [WORD_W-1:0] q);
    return WORD_W'(q) + MID_SCALE;
  endfunction
  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // bounded wait for a state of awake and the pin enables
  task automatic wait_for(input logic aw, input logic [WORD_W-1:0] oe);
    int n;
    checked++;
    for (n = 0; n < 40 && (awake !== aw || word_oe !== oe); n++) tick();
    if (n == 40) begin
      err_count++;
      $display("wrong value at %0t: state wait timed out", $time);
      finish_test();
    end
  endtask
  // corners first, then random words, one per clock
  task automatic stream(input int cnt);
    logic [WORD_W-1:0] exp;
    logic [WORD_W-1:0] prev;
    logic [WORD_W-1:0] corner [4];
    corner = '{12'h800, 12'h7ff, 12'h000, 12'hfff};
    expq = {};
    repeat (LAT + 2) expq.push_back(conv(quant));
    prev = conv(quant);
    for (int i = 0; i < cnt; i++) begin
      tick();
      exp = expq.pop_front();
      chk(word, exp);
      if (i > 0) chk(cap, prev);
      prev = exp;
      quant = (i < 4) ? corner[i] : WORD_W'($urandom);
      expq.push_back(conv(quant));
    end
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h55f0ef5d));
    repeat (4) @(posedge mclk);
    #1 rst_n = 1;
    wait_for(1'b1, '1);
    repeat (LAT + 8) tick();
    stream(40);
    // clock enable low: nothing may move, not even the pin synchronisers
    ce = 0;
    hold = word;
    oe_n = 1;
    for (int i = 0; i < 10; i++) begin
      quant = WORD_W'($urandom);
      tick();
    end
    chk(word, hold);
    chk(word_oe, '1);
    oe_n = 0;
    ce = 1;
    tick();
    oe_n = 1;
    wait_for(1'b1, '0);
    oe_n = 0;
    wait_for(1'b1, '1);
    sleep = 1;
    wait_for(1'b0, '1);
    hold = word;
    for (int i = 0; i < 10; i++) begin
      quant = WORD_W'($urandom);
      tick();
    end
    chk(word, hold);
    sleep = 0;
    wait_for(1'b1, '1);
    repeat (LAT + 8) tick();
    stream(40);
    finish_test();
  end
endmodule
`default_nettype wire
